// ==== pou_consts.svh ====
// Constants of the process output update block: offsets, fields, reset values, timing
`ifndef POU_CONSTS_SVH
`define POU_CONSTS_SVH

// ****************************************
// Timing
// ****************************************
`define POU_CLK_HZ 20000000
`define POU_TICK_US 10000
`define POU_CONV_STEPS 34

// ****************************************
// Value spans
// ****************************************
`define POU_PCT_FULL 100000
`define POU_DUTY_FULL 10000
`define POU_FREQ_MIN 1
`define POU_FREQ_MAX 1000

// ****************************************
// Register offsets
// ****************************************
`define POU_ADR_AO_STRIDE 8'h10
`define POU_OFS_CFG 8'h00
`define POU_OFS_RANGE 8'h04
`define POU_OFS_CMD 8'h08
`define POU_OFS_CODE 8'h0C
`define POU_ADR_RELAY1 8'h20
`define POU_ADR_RELAY2 8'h24
`define POU_ADR_FREQ 8'h28
`define POU_ADR_DUTY 8'h2C
`define POU_ADR_STATUS 8'h30

// ****************************************
// Fields and reset values
// ****************************************
`define POU_CFG_TYPE_BIT 0
`define POU_CFG_INV_BIT 1
`define POU_RNG_HI_LSB 16
`define POU_ST_OVERRUN_BIT 3
`define POU_ST_BADFREQ_BIT 4
`define POU_RST_AO_CFG 2'h0
`define POU_RST_AO_RNG 32'hFFFF0000
`define POU_RST_FREQ 10'h064
`define POU_CH_IMG_W 34
`define POU_IMG_W 78

`endif

// ==== pou_pkg.sv ====
// Types shared by the process output update block
package pou_pkg;
  typedef enum logic [2:0] {
    POU_ST_WAIT = 3'b001,
    POU_ST_CALC = 3'b010,
    POU_ST_CONV = 3'b100
  } pou_state_e;
  typedef logic [15:0] pou_code_t;
  typedef logic [16:0] pou_pct_t;
endpackage

// ==== pou_interp_if.sv ====
// Link between the sequencer and one range interpolation engine
`timescale 1ns/1ns
interface pou_interp_if;
  import pou_pkg::*;
  logic start;
  pou_pct_t pct;
  pou_code_t lo;
  pou_code_t hi;
  logic inv;
  logic busy;
  logic done;
  pou_code_t code;
  modport ctl (output start, output pct, output lo, output hi, output inv, input busy, input done, input code);
  modport eng (input start, input pct, input lo, input hi, input inv, output busy, output done, output code);
endinterface

// ==== pou_interp.sv ====
// Range interpolation engine: percent to converter code by serial division
`timescale 1ns/1ns
`include "pou_consts.svh"
module pou_interp
  import pou_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_srst,
  pou_interp_if.eng bus
);
  localparam logic [16:0] PCT_FULL = 17'(`POU_PCT_FULL);
  localparam logic [5:0] STEPS = 6'(`POU_CONV_STEPS);

  pou_pct_t p_eff;
  logic neg;
  pou_code_t mag;
  logic [33:0] num;
  logic [17:0] trial;
  logic fits;
  logic [33:0] quo_nxt;
  logic [17:0] rem_r;
  logic [33:0] quo_r;
  logic [5:0] cnt_r;
  logic busy_r;
  logic done_r;
  logic neg_r;
  pou_code_t lo_r;
  pou_code_t code_r;
  pou_pct_t p_r;

  // Inversion swaps the ends by mirroring the percentage
  assign p_eff = bus.inv ? PCT_FULL - bus.pct : bus.pct;
  assign neg = bus.hi < bus.lo;
  assign mag = neg ? bus.lo - bus.hi : bus.hi - bus.lo;
  // Half divisor added first so the quotient rounds to nearest
  assign num = 34'(mag) * 34'(p_eff) + 34'(`POU_PCT_FULL / 2);
  assign trial = {rem_r[16:0], quo_r[33]};
  assign fits = trial >= 18'(`POU_PCT_FULL);
  assign quo_nxt = {quo_r[32:0], fits};

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      rem_r <= 18'h00000;
      quo_r <= 34'h000000000;
      cnt_r <= 6'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      neg_r <= 1'b0;
      lo_r <= 16'h0000;
      code_r <= 16'h0000;
      p_r <= 17'h00000;
    end
    else if (bus.start)
    begin
      rem_r <= 18'h00000;
      quo_r <= num;
      cnt_r <= STEPS;
      busy_r <= 1'b1;
      done_r <= 1'b0;
      neg_r <= neg;
      lo_r <= bus.lo;
      p_r <= p_eff;
    end
    else if (busy_r)
    begin
      rem_r <= fits ? trial - 18'(`POU_PCT_FULL) : trial;
      quo_r <= quo_nxt;
      cnt_r <= cnt_r - 6'h01;
      busy_r <= cnt_r != 6'h01;
      done_r <= cnt_r == 6'h01;
      if (cnt_r == 6'h01)
        code_r <= neg_r ? lo_r - quo_nxt[15:0] : lo_r + quo_nxt[15:0];
    end
    else
      done_r <= 1'b0;
  end

  assign bus.busy = busy_r;
  assign bus.done = done_r;
  assign bus.code = code_r;

  // ****************************************
  // Checks
  // ****************************************
  a_zero_end: assert property (@(posedge i_mclk) disable iff (i_srst)
    done_r && p_r == 17'h00000 |-> code_r == lo_r)
    else $error("zero percent did not give the lower end");
  a_conv_len: assert property (@(posedge i_mclk) disable iff (i_srst)
    bus.start |-> ##35 done_r)
    else $error("conversion length wrong");
endmodule

// ==== pou_output_update.sv ====
// Periodic output stage: two analogue channels, two relays, one pulse output
`timescale 1ns/1ns
`include "pou_consts.svh"
// Contract
// - Refresh all outputs once per 10 ms tick
// - Type voltage or current picks driven path
// - Upper and lower range anywhere in span
// - 100 percent upper, 0 percent lower
// - Inversion swaps which end means 100 percent
// - Analogue step no coarser than 0.005 percent
// - Channel settings survive power loss
// - Two independent relays refreshed every tick
// - Pulse frequency whole hertz 1 to 1000
// - Duty 0.00 to 100.00 in 0.01 steps
// - Square wave high time follows duty
// - Inputs, equations, loops, then outputs update
// - Analogue and duty commands clamped to span
// - Relay on for positive, off otherwise
module pou_output_update
  import pou_pkg::*;
#(
  parameter int CLK_HZ = `POU_CLK_HZ,
  parameter int TICK_CYCLES = `POU_CLK_HZ / 1000000 * `POU_TICK_US,
  parameter int ACC_W = 25
)
(
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output logic o_cycle_start,
  input wire logic i_calc_done,
  input wire logic i_cfg_restore,
  input wire logic [`POU_IMG_W-1:0] i_cfg_image,
  output logic o_cfg_save,
  output logic [`POU_IMG_W-1:0] o_cfg_image,
  output logic [15:0] o_chan1_voltage_pin,
  output logic [15:0] o_chan1_current_pin,
  output logic o_chan1_voltage_en,
  output logic o_chan1_current_en,
  output logic [15:0] o_chan2_voltage_pin,
  output logic [15:0] o_chan2_current_pin,
  output logic o_chan2_voltage_en,
  output logic o_chan2_current_en,
  output logic o_relay_out_one,
  output logic o_relay_out_two,
  output logic o_pulse_output_one
);
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam logic [ACC_W-1:0] ACC_TOP = ACC_W'(CLK_HZ);
  localparam logic [ACC_W-1:0] DUTY_STEP = ACC_W'(CLK_HZ / `POU_DUTY_FULL);

  function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        res[8*b +: 8] = nw[8*b +: 8];
    return res;
  endfunction

  // Negative and oversize commands pin to the span ends
  function automatic pou_pct_t clamp_pct(input logic [31:0] v);
    if (v[31])
      return 17'h00000;
    else if (v > 32'(`POU_PCT_FULL))
      return 17'(`POU_PCT_FULL);
    else
      return v[16:0];
  endfunction

  // ****************************************
  // Register bus
  // ****************************************
  logic ack_r;
  logic [31:0] rd_r;
  logic [31:0] rd_nxt;
  wire wb_req = i_wb_cyc & i_wb_stb & ~ack_r;
  wire wb_wr = wb_req & i_wb_we;
  wire hit_relay1 = i_wb_adr == `POU_ADR_RELAY1;
  wire hit_relay2 = i_wb_adr == `POU_ADR_RELAY2;
  wire hit_freq = i_wb_adr == `POU_ADR_FREQ;
  wire hit_duty = i_wb_adr == `POU_ADR_DUTY;
  wire hit_status = i_wb_adr == `POU_ADR_STATUS;

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      ack_r <= 1'b0;
    else
      ack_r <= wb_req;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      rd_r <= 32'h00000000;
    else if (wb_req)
      rd_r <= rd_nxt;
  end

  assign o_wb_ack = ack_r;
  assign o_wb_dat = rd_r;

  // ****************************************
  // Sequencer
  // ****************************************
  pou_state_e state_r;
  pou_state_e state_nxt;
  logic [TICK_W-1:0] tick_cnt_r;
  wire tick = tick_cnt_r == TICK_W'(TICK_CYCLES - 1);
  logic conv_go;
  logic apply;
  logic [1:0] conv_done;
  logic overrun_r;
  logic badfreq_r;

  always_ff @(posedge i_mclk)
  begin
    if (i_srst || tick)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick_cnt_r + TICK_W'(1);
  end

  // Outputs move 35 cycles after the core reports its cycle finished, or 35 cycles after the next tick if it has not
  assign conv_go = state_r == POU_ST_CALC && (i_calc_done || tick);
  assign apply = state_r == POU_ST_CONV && conv_done == 2'b11;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      POU_ST_WAIT: if (tick) state_nxt = POU_ST_CALC;
      POU_ST_CALC: if (conv_go) state_nxt = POU_ST_CONV;
      POU_ST_CONV: if (apply) state_nxt = POU_ST_WAIT;
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      state_r <= POU_ST_WAIT;
      o_cycle_start <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      o_cycle_start <= state_r == POU_ST_WAIT && tick;
    end
  end

  // ****************************************
  // Analogue channels
  // ****************************************
  logic [1:0] ao_cfg_r [2];
  logic [31:0] ao_rng_r [2];
  logic [31:0] ao_cmd_r [2];
  pou_code_t ao_code_r [2];
  pou_code_t volt_pin_r [2];
  pou_code_t cur_pin_r [2];
  logic volt_en_r [2];
  logic cur_en_r [2];
  logic [1:0] cfg_wr;
  logic [31:0] ch_rd [2];
  logic [1:0] ch_hit;

  for (genvar g = 0; g < 2; g++)
  begin : g_ch
    localparam logic [7:0] BASE = 8'(`POU_ADR_AO_STRIDE * g);
    localparam int IMG_LSB = `POU_CH_IMG_W * g;
    wire hit_cfg = i_wb_adr == BASE + `POU_OFS_CFG;
    wire hit_rng = i_wb_adr == BASE + `POU_OFS_RANGE;
    wire hit_cmd = i_wb_adr == BASE + `POU_OFS_CMD;
    wire hit_code = i_wb_adr == BASE + `POU_OFS_CODE;
    wire [31:0] cfg_m = wb_merge({30'h00000000, ao_cfg_r[g]}, i_wb_dat, i_wb_sel);
    wire is_cur = ao_cfg_r[g][`POU_CFG_TYPE_BIT];
    pou_interp_if u_if ();

    always_ff @(posedge i_mclk)
    begin
      if (i_srst)
      begin
        ao_cfg_r[g] <= `POU_RST_AO_CFG;
        ao_rng_r[g] <= `POU_RST_AO_RNG;
        ao_cmd_r[g] <= 32'h00000000;
      end
      else if (i_cfg_restore)
      begin
        ao_cfg_r[g] <= i_cfg_image[IMG_LSB +: 2];
        ao_rng_r[g] <= i_cfg_image[IMG_LSB + 2 +: 32];
      end
      else if (wb_wr)
      begin
        if (hit_cfg)
          ao_cfg_r[g] <= cfg_m[1:0];
        if (hit_rng)
          ao_rng_r[g] <= wb_merge(ao_rng_r[g], i_wb_dat, i_wb_sel);
        if (hit_cmd)
          ao_cmd_r[g] <= wb_merge(ao_cmd_r[g], i_wb_dat, i_wb_sel);
      end
    end

    assign u_if.start = conv_go;
    assign u_if.pct = clamp_pct(ao_cmd_r[g]);
    assign u_if.lo = ao_rng_r[g][15:0];
    assign u_if.hi = ao_rng_r[g][`POU_RNG_HI_LSB +: 16];
    assign u_if.inv = ao_cfg_r[g][`POU_CFG_INV_BIT];
    assign conv_done[g] = u_if.done;

    pou_interp u_interp (
      .i_mclk(i_mclk),
      .i_srst(i_srst),
      .bus(u_if.eng)
    );

    // Unselected path is parked at zero and left undriven
    always_ff @(posedge i_mclk)
    begin
      if (i_srst)
      begin
        ao_code_r[g] <= 16'h0000;
        volt_pin_r[g] <= 16'h0000;
        cur_pin_r[g] <= 16'h0000;
        volt_en_r[g] <= 1'b0;
        cur_en_r[g] <= 1'b0;
      end
      else if (apply)
      begin
        ao_code_r[g] <= u_if.code;
        volt_pin_r[g] <= is_cur ? 16'h0000 : u_if.code;
        cur_pin_r[g] <= is_cur ? u_if.code : 16'h0000;
        volt_en_r[g] <= ~is_cur;
        cur_en_r[g] <= is_cur;
      end
    end

    assign cfg_wr[g] = wb_wr & (hit_cfg | hit_rng);
    assign ch_hit[g] = hit_cfg | hit_rng | hit_cmd | hit_code;
    assign ch_rd[g] = hit_cfg ? {30'h00000000, ao_cfg_r[g]} :
                      hit_rng ? ao_rng_r[g] :
                      hit_cmd ? ao_cmd_r[g] :
                      hit_code ? {16'h0000, ao_code_r[g]} : 32'h00000000;
    assign o_cfg_image[IMG_LSB +: `POU_CH_IMG_W] = {ao_rng_r[g], ao_cfg_r[g]};
  end

  assign o_chan1_voltage_pin = volt_pin_r[0];
  assign o_chan1_current_pin = cur_pin_r[0];
  assign o_chan1_voltage_en = volt_en_r[0];
  assign o_chan1_current_en = cur_en_r[0];
  assign o_chan2_voltage_pin = volt_pin_r[1];
  assign o_chan2_current_pin = cur_pin_r[1];
  assign o_chan2_voltage_en = volt_en_r[1];
  assign o_chan2_current_en = cur_en_r[1];

  // ****************************************
  // Relays and pulse channel
  // ****************************************
  logic [31:0] relay_cmd_r [2];
  logic relay_r [2];
  logic [9:0] freq_r;
  logic [9:0] freq_act_r;
  logic [31:0] duty_r;
  logic [13:0] duty_act_r;
  logic [ACC_W-1:0] acc_r;
  logic pulse_r;
  wire [31:0] freq_m = wb_merge({22'h000000, freq_r}, i_wb_dat, i_wb_sel);
  wire freq_ok = freq_m >= 32'(`POU_FREQ_MIN) && freq_m <= 32'(`POU_FREQ_MAX);
  wire freq_bad_wr = wb_wr && hit_freq && !freq_ok;
  wire [9:0] img_freq = i_cfg_image[2*`POU_CH_IMG_W +: 10];
  wire img_freq_ok = img_freq >= 10'(`POU_FREQ_MIN) && img_freq <= 10'(`POU_FREQ_MAX);
  wire [31:0] duty_clamp = duty_r[31] ? 32'h00000000 :
                           duty_r > 32'(`POU_DUTY_FULL) ? 32'(`POU_DUTY_FULL) : duty_r;
  wire [ACC_W-1:0] acc_sum = acc_r + ACC_W'(freq_act_r);
  wire [ACC_W-1:0] acc_nxt = acc_sum >= ACC_TOP ? acc_sum - ACC_TOP : acc_sum;
  wire [ACC_W-1:0] thr = ACC_W'(duty_act_r) * DUTY_STEP;
  wire status_w1c = wb_wr && hit_status;

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      relay_cmd_r[0] <= 32'h00000000;
      relay_cmd_r[1] <= 32'h00000000;
      freq_r <= `POU_RST_FREQ;
      duty_r <= 32'h00000000;
    end
    else if (i_cfg_restore)
    begin
      // A blank or damaged image keeps the last valid frequency
      if (img_freq_ok)
        freq_r <= img_freq;
    end
    else if (wb_wr)
    begin
      if (hit_relay1)
        relay_cmd_r[0] <= wb_merge(relay_cmd_r[0], i_wb_dat, i_wb_sel);
      if (hit_relay2)
        relay_cmd_r[1] <= wb_merge(relay_cmd_r[1], i_wb_dat, i_wb_sel);
      if (hit_freq && freq_ok)
        freq_r <= freq_m[9:0];
      if (hit_duty)
        duty_r <= wb_merge(duty_r, i_wb_dat, i_wb_sel);
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      relay_r[0] <= 1'b0;
      relay_r[1] <= 1'b0;
      freq_act_r <= `POU_RST_FREQ;
      duty_act_r <= 14'h0000;
    end
    else if (apply)
    begin
      // Any positive signed value switches the relay on
      relay_r[0] <= !relay_cmd_r[0][31] && relay_cmd_r[0] != 32'h00000000;
      relay_r[1] <= !relay_cmd_r[1][31] && relay_cmd_r[1] != 32'h00000000;
      freq_act_r <= freq_r;
      duty_act_r <= duty_clamp[13:0];
    end
  end

  // Phase accumulator keeps whole-hertz periods exact with no divider
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      acc_r <= '0;
      pulse_r <= 1'b0;
    end
    else
    begin
      acc_r <= acc_nxt;
      pulse_r <= acc_nxt < thr;
    end
  end

  assign o_relay_out_one = relay_r[0];
  assign o_relay_out_two = relay_r[1];
  assign o_pulse_output_one = pulse_r;

  // ****************************************
  // Status and saved image
  // ****************************************
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      overrun_r <= 1'b0;
      badfreq_r <= 1'b0;
      o_cfg_save <= 1'b0;
    end
    else
    begin
      // A new event wins over a clear in the same cycle
      overrun_r <= (state_r == POU_ST_CALC && tick && !i_calc_done) ||
                   (overrun_r && !(status_w1c && i_wb_sel[0] && i_wb_dat[`POU_ST_OVERRUN_BIT]));
      badfreq_r <= freq_bad_wr ||
                   (badfreq_r && !(status_w1c && i_wb_sel[0] && i_wb_dat[`POU_ST_BADFREQ_BIT]));
      o_cfg_save <= |cfg_wr || (wb_wr && hit_freq && freq_ok);
    end
  end

  assign o_cfg_image[2*`POU_CH_IMG_W +: 10] = freq_r;

  assign rd_nxt = ch_hit[0] ? ch_rd[0] :
                  ch_hit[1] ? ch_rd[1] :
                  hit_relay1 ? relay_cmd_r[0] :
                  hit_relay2 ? relay_cmd_r[1] :
                  hit_freq ? {22'h000000, freq_r} :
                  hit_duty ? duty_r :
                  hit_status ? {24'h000000, state_r, badfreq_r, overrun_r, pulse_r, relay_r[1], relay_r[0]} :
                  32'h00000000;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_srst);

  logic [TICK_W:0] since_r;
  logic seen_r;
  always_ff @(posedge i_mclk)
  begin
    if (i_srst || tick)
      since_r <= '0;
    else
      since_r <= since_r + (TICK_W + 1)'(1);
    if (i_srst || tick)
      seen_r <= 1'b0;
    else if (apply)
      seen_r <= 1'b1;
  end

  a_tick_period: assert property (tick |-> since_r == (TICK_W + 1)'(TICK_CYCLES - 1))
    else $error("refresh tick spacing wrong");
  a_one_refresh: assert property (apply |-> !seen_r)
    else $error("more than one refresh in a tick");
  a_core_first: assert property (!$past(apply) |->
    $stable(o_chan1_voltage_pin) && $stable(o_chan2_current_pin) &&
    $stable(o_relay_out_one) && $stable(o_relay_out_two))
    else $error("outputs moved outside the update step");
  a_conv_bound: assert property (conv_go |-> ##[30:40] apply)
    else $error("conversion did not finish in time");
  a_relay_sign: assert property (apply |=> o_relay_out_one == $past($signed(relay_cmd_r[0]) > 0))
    else $error("relay level does not follow sign");
  a_path_pick: assert property (apply |=> o_chan1_current_en == $past(ao_cfg_r[0][0]) && !o_chan1_voltage_en == o_chan1_current_en)
    else $error("wrong analogue path enabled");
  a_path_idle: assert property (!o_chan2_voltage_en |-> o_chan2_voltage_pin == 16'h0000)
    else $error("idle voltage path driven");
  a_freq_range: assert property (freq_r >= 10'(`POU_FREQ_MIN) && freq_r <= 10'(`POU_FREQ_MAX))
    else $error("pulse frequency out of range");
  a_duty_full: assert property (duty_act_r == 14'(`POU_DUTY_FULL) && $stable(duty_act_r) [*2] |-> pulse_r)
    else $error("full duty not held high");
  a_duty_zero: assert property (duty_act_r == 14'h0000 && $stable(duty_act_r) [*2] |-> !pulse_r)
    else $error("zero duty not held low");
  a_pct_clamp: assert property (apply |-> g_ch[0].u_if.pct <= 17'(`POU_PCT_FULL))
    else $error("percentage not clamped");

  c_refresh: cover property (tick ##[1:1000] apply);
  c_overrun: cover property (state_r == POU_ST_CALC && tick && !i_calc_done);
  c_restore: cover property (i_cfg_restore ##1 o_cfg_image[1]);
  c_inverted: cover property (apply && ao_cfg_r[0][1]);
endmodule

// ==== pou_field_load.sv ====
// Field actuator model: two analogue loads that follow the switched-in path
`timescale 1ns/1ns
module pou_field_load
(
  input wire logic [1:0][15:0] i_volt,
  input wire logic [1:0][15:0] i_curr,
  input wire logic [1:0] i_volt_en,
  input wire logic [1:0] i_curr_en,
  output logic [1:0][15:0] o_level,
  output logic [1:0][1:0] o_path,
  output logic [1:0] o_leak
);
  genvar k;
  for (k = 0; k < 2; k++)
  begin : g_ch
    // An open path reads as 0 at the load
    assign o_level[k] = i_curr_en[k] ? i_curr[k] : (i_volt_en[k] ? i_volt[k] : 16'h0000);
    assign o_path[k] = {i_curr_en[k], i_volt_en[k]};
    // Idle path must stay quiet or the second load sees a stray level
    assign o_leak[k] = i_curr_en[k] ? (i_volt[k] !== 16'h0000) : (i_curr[k] !== 16'h0000);
  end
endmodule

// ==== process_output_update_tb.sv ====
// Self-checking bench for the process output update block
`timescale 1ns/1ns
`include "pou_consts.svh"
module process_output_update_tb;
  import pou_pkg::*;
  localparam int TICK = 200;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic done = 1'b0;
  logic rest = 1'b0;
  logic [`POU_IMG_W-1:0] img = '0;
  logic [31:0] rdat;
  logic ack, cstart, save, ve1, ce1, ve2, ce2, r1, r2, pw;
  logic [`POU_IMG_W-1:0] oimg;
  logic [15:0] v1, c1, v2, c2;
  logic [1:0][15:0] lvl;
  logic [1:0][1:0] path;
  logic [1:0] leak;
  logic saw_save = 1'b0;
  int cnt = 0;
  int t_start = 0;
  int err_count = 0;
  int samples_checked = 0;

  always #25 clk = ~clk;
  always @(posedge clk) cnt <= cnt + 1;
  always @(posedge clk) if (save === 1'b1) saw_save <= 1'b1;

  pou_output_update #(.TICK_CYCLES(TICK)) pou_output_update_inst (.i_mclk(clk), .i_srst(rst),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .o_cycle_start(cstart), .i_calc_done(done), .i_cfg_restore(rest),
    .i_cfg_image(img), .o_cfg_save(save), .o_cfg_image(oimg), .o_chan1_voltage_pin(v1),
    .o_chan1_current_pin(c1), .o_chan1_voltage_en(ve1), .o_chan1_current_en(ce1),
    .o_chan2_voltage_pin(v2), .o_chan2_current_pin(c2), .o_chan2_voltage_en(ve2),
    .o_chan2_current_en(ce2), .o_relay_out_one(r1), .o_relay_out_two(r2), .o_pulse_output_one(pw));

  pou_field_load pou_field_load_inst (.i_volt({v2, v1}), .i_curr({c2, c1}), .i_volt_en({ve2, ve1}),
    .i_curr_en({ce2, ce1}), .o_level(lvl), .o_path(path), .o_leak(leak));

  // ****************************************
  // Bus and compare helpers
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk);
    end
    q = rdat;
    chk("bus_ack", 32'h1, 32'(ack));
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask

  // Plays the core: answers each cycle start some cycles late
  task automatic refresh;
    int n;
    logic [16:0] snap;
    n = 0;
    while (cstart !== 1'b1 && n < 1000)
    begin
      n++;
      @(posedge clk);
    end
    chk("cycle_start", 32'h1, 32'(cstart));
    t_start = cnt;
    snap = {r1, v1};
    repeat (3) @(posedge clk);
    chk("early_update", 32'(snap), 32'({r1, v1}));
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    repeat (40) @(posedge clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic reset_case;
    logic [31:0] q;
    chk("rst_freq", 32'd100, 32'(oimg[77:68]));
    chk("rst_rng", 32'hFFFF0000, oimg[33:2]);
    chk("rst_flags", 32'h0, 32'({ve1, ce1, ve2, ce2, r1, r2, pw, cstart, save, ack}));
    chk("rst_pins1", 32'h0, {v1, c1});
    chk("rst_pins2", 32'h0, {v2, c2});
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, q);
    chk("unmapped", 32'h0, q);
    $display("reset case done");
  endtask

  task automatic restore_case;
    logic [31:0] q;
    img <= {10'h1F4, 32'h80002000, 2'h1, 32'h70001000, 2'h2};
    rest <= 1'b1;
    @(posedge clk);
    rest <= 1'b0;
    @(posedge clk);
    chk("img_a", img[31:0], oimg[31:0]);
    chk("img_b", img[63:32], oimg[63:32]);
    chk("img_c", 32'(img[77:64]), 32'(oimg[77:64]));
    rd(8'h14, q);
    chk("rng2_reg", 32'h80002000, q);
    saw_save <= 1'b0;
    wr(8'h00, 32'h0);
    chk("save_pulse", 32'h1, 32'(saw_save));
    $display("restore case done");
  endtask

  task automatic an_case(input int ch, input logic [1:0] cfg, input logic [31:0] rng, input int cmd);
    logic [31:0] q;
    int p;
    longint e;
    wr(8'(ch * 16), {30'h0, cfg});
    wr(8'(ch * 16 + 4), rng);
    wr(8'(ch * 16 + 8), 32'(cmd));
    refresh();
    p = cmd < 0 ? 0 : (cmd > 100000 ? 100000 : cmd);
    if (cfg[1])
      p = 100000 - p;
    e = (longint'(rng[15:0]) * 100000 + (longint'(rng[31:16]) - longint'(rng[15:0])) * p + 50000) / 100000;
    rd(8'(ch * 16 + 12), q);
    chk("code_reg", 32'(e), q);
    chk("load_level", 32'(e), 32'(lvl[ch]));
    chk("path", {30'h0, cfg[0], ~cfg[0]}, 32'(path[ch]));
    chk("idle_path", 32'h0, 32'(leak[ch]));
    $display("analogue case ch%0d cmd %0d done", ch + 1, cmd);
  endtask

  task automatic relay_case(input int a, input int b, input logic ea, input logic eb);
    logic [31:0] q;
    wr(8'h20, 32'(a));
    wr(8'h24, 32'(b));
    refresh();
    chk("relay_one", 32'(ea), 32'(r1));
    chk("relay_two", 32'(eb), 32'(r2));
    rd(8'h30, q);
    chk("relay_stat", {30'h0, eb, ea}, {30'h0, q[1:0]});
    $display("relay case done");
  endtask

  task automatic freq_case;
    logic [31:0] q;
    wr(8'h28, 32'd0);
    wr(8'h28, 32'd1001);
    rd(8'h28, q);
    chk("freq_kept", 32'd500, q);
    rd(8'h30, q);
    chk("bad_freq", 32'h1, 32'(q[4]));
    wr(8'h30, 32'h10);
    rd(8'h30, q);
    chk("bad_clear", 32'h0, 32'(q[4]));
    wr(8'h28, 32'd1000);
    chk("freq_img", 32'd1000, 32'(oimg[77:68]));
    $display("frequency case done");
  endtask

  task automatic tick_case;
    int t;
    refresh();
    t = t_start;
    refresh();
    chk("tick_gap", 32'(TICK), 32'(t_start - t));
    $display("tick case done");
  endtask

  // One full period at 1000 Hz is 20000 cycles
  task automatic pulse_case(input int duty, input int exp_hi);
    int hi;
    hi = 0;
    wr(8'h2C, 32'(duty));
    refresh();
    repeat (20000)
    begin
      @(posedge clk);
      if (pw === 1'b1)
        hi++;
    end
    chk("pulse_high", 32'(exp_hi), 32'(hi));
    $display("pulse case duty %0d done", duty);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (98000) @(posedge clk);
    err_count++;
    results();
  end

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    reset_case();
    restore_case();
    an_case(0, 2'h0, 32'h90001000, 100000);
    an_case(0, 2'h0, 32'h90001000, 0);
    an_case(0, 2'h0, 32'h90001000, 200000);
    an_case(0, 2'h0, 32'h90001000, -7);
    an_case(0, 2'h2, 32'h90001000, 100000);
    an_case(0, 2'h3, 32'h90001000, 25000);
    an_case(1, 2'h1, 32'hFFFF0000, 5);
    an_case(1, 2'h3, 32'hFFFF0000, 0);
    an_case(1, 2'h0, 32'hC0003000, 50000);
    relay_case(1, -41, 1'b1, 1'b0);
    relay_case(0, 32'h7FFFFFFF, 1'b0, 1'b1);
    relay_case(-1, 0, 1'b0, 1'b0);
    tick_case();
    freq_case();
    pulse_case(0, 0);
    pulse_case(1, 2);
    pulse_case(5000, 10000);
    pulse_case(20000, 20000);
    results();
  end
endmodule
